// ===== config_word_and_reset_cause.sv
// Purpose: decode configuration and calibration words, classify resets
// Assumes: programmer port usable only while prog_mode is high
// Notes:
// Notes on behaviour
// - programmed bit reads 0, erased reads 1; options decoded so
// - configuration word fetched from word address 2007h and applied
// - space 2000h-3FFFh writable only in programming mode
// - oscillator trim held in calibration word at 2008h
// - bulk erase leaves calibration word untouched
// - six reset causes distinguished
// - unaffected registers hold value through every non-power-on reset
// - other registers load reset values on any reset except wake-up
// - watchdog wake-up from sleep resumes without register reset
// - timeout and power-down flags encode the last reset situation
// - reset pin is glitch filtered
// - flag encoding per cause: por, bor, to, pd
// - power-up timer disable bit 1 disables the timer
// - pin select 0 internal reset; 1 external active-low pin
// - brown-out mode 10 disables detection during sleep
`timescale 1ns/1ps
`default_nettype none
module config_word_and_reset_cause (
    input  wire logic        clk,            // core clock
    input  wire logic        reset,          // power-on reset, sync high
    input  wire logic        prog_mode,      // programming mode active
    input  wire logic        prog_wr,        // programmer write strobe
    input  wire logic        prog_erase,     // programmer bulk erase strobe
    input  wire logic [13:0] prog_addr,      // programmer word address
    input  wire logic [13:0] prog_wdata,     // programmer write data
    output logic      [13:0] prog_rdata,     // word read back
    input  wire logic        reset_pin_n,    // external reset pin level
    input  wire logic        brownout_det,   // supply below threshold
    input  wire logic        wdt_timeout,    // watchdog expiry pulse
    input  wire logic        sleeping,       // core is in sleep
    input  wire logic        flag_wr,        // software writes flags
    input  wire logic [1:0]  flag_wdata,     // {por, bor} written value
    input  wire logic [7:0]  reg_wdata,      // register write data
    input  wire logic        keep_wr,        // write unaffected register
    input  wire logic        reg_wr,         // write resettable register
    output logic      [13:0] device_configuration_word, // applied word
    output logic      [7:0]  osc_trim,       // calibration trim
    output logic             debugger_en,    // debugger enabled
    output logic             clock_output_enable, // clock out on pin
    output logic      [1:0]  self_write_protect_field, // write protect
    output logic             brownout_en,    // brown-out detect active
    output logic             code_protect_en, // code protection on
    output logic             ext_reset_pin_en, // pin is reset input
    output logic             power_up_timer_en, // timer enabled
    output logic             watchdog_en,    // watchdog enabled
    output logic             ext_clock_sel,  // external clock input
    output logic             core_reset,     // registers reset pulse
    output logic             wake_resume,    // wake-up, no reset
    output logic             timeout_flag,   // status time-out flag
    output logic             power_down_flag, // status power-down flag
    output logic             por_flag,       // power-on flag
    output logic             brownout_reset, // brown-out flag
    output logic      [2:0]  last_cause,     // last reset cause
    output logic      [7:0]  keep_reg,       // unaffected register
    output logic      [7:0]  reset_reg       // resettable register
);
    logic [13:0] cfg_ff, cal_ff;
    logic [13:0] nv_cfg_ff;
    logic [7:0]  nv_cal_ff;
    logic        pin_s1_ff, pin_s2_ff;
    logic [3:0]  flt_ff;
    logic        pin_lvl_ff, pin_lvl_d_ff;
    logic        to_ff, pd_ff, por_ff, bor_ff;
    logic        bor_s1_ff, bor_s2_ff, bor_d_ff;
    logic [7:0]  keep_ff, rst_ff;
    cfg_pkg::cause_e cause_ff;
    logic        pin_fall, bor_ev, wdt_ev, any_rst, prog_ok;

    function automatic logic in_special(input logic [13:0] a);
        in_special = (a >= cfg_pkg::SPECIAL_LO) && (a <= cfg_pkg::SPECIAL_HI);
    endfunction

    assign prog_ok = prog_mode && in_special(prog_addr);

    // nonvolatile store, writes replace the word, unimplemented bits set
    always_ff @(posedge clk) begin
        if (reset) begin
        end else if (prog_mode && prog_erase) begin
            nv_cfg_ff <= cfg_pkg::ERASED_WORD;
        end else if (prog_ok && prog_wr) begin
            if (prog_addr == cfg_pkg::CONFIG_ADDR) begin
                nv_cfg_ff <= prog_wdata | cfg_pkg::UNIMPL_MASK;
            end
            if (prog_addr == cfg_pkg::CALIB_ADDR) begin
                nv_cal_ff <= prog_wdata[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prog_rdata <= cfg_pkg::ERASED_WORD;
        end else if (prog_ok && prog_addr == cfg_pkg::CONFIG_ADDR) begin
            prog_rdata <= nv_cfg_ff;
        end else if (prog_ok && prog_addr == cfg_pkg::CALIB_ADDR) begin
            prog_rdata <= {6'h00, nv_cal_ff};
        end else begin
            prog_rdata <= cfg_pkg::ERASED_WORD;
        end
    end

    // fetch on any core reset outside programming mode
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_ff <= cfg_pkg::ERASED_WORD;
            cal_ff <= cfg_pkg::ERASED_WORD;
        end else if (core_reset && !prog_mode) begin
            cfg_ff <= nv_cfg_ff | cfg_pkg::UNIMPL_MASK;
            cal_ff <= {6'h00, nv_cal_ff};
        end
    end

    assign device_configuration_word = cfg_ff;
    assign osc_trim                  = cal_ff[7:0];
    assign debugger_en               = !cfg_ff[cfg_pkg::B_DEBUG];
    assign clock_output_enable       = !cfg_ff[cfg_pkg::B_CLKOUT];
    assign self_write_protect_field  =
        cfg_ff[cfg_pkg::B_WRT_HI:cfg_pkg::B_WRT_LO];
    assign code_protect_en           = !cfg_ff[cfg_pkg::B_CP];
    assign ext_reset_pin_en          = cfg_ff[cfg_pkg::B_RSTPIN];
    assign power_up_timer_en         = !cfg_ff[cfg_pkg::B_PUT];
    assign watchdog_en               = cfg_ff[cfg_pkg::B_WDT];
    assign ext_clock_sel             = cfg_ff[cfg_pkg::B_OSC];
    always_comb begin
        unique case (cfg_ff[cfg_pkg::B_BOR_HI:cfg_pkg::B_BOR_LO])
            cfg_pkg::BOR_ON:        brownout_en = 1'b1;
            cfg_pkg::BOR_SLEEP_OFF: brownout_en = !sleeping;
            default:                brownout_en = 1'b0;
        endcase
    end

    // reset pin sync and glitch filter
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
        end else begin
            pin_s1_ff <= reset_pin_n;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flt_ff       <= 4'h0;
            pin_lvl_ff   <= 1'b1;
            pin_lvl_d_ff <= 1'b1;
        end else begin
            pin_lvl_d_ff <= pin_lvl_ff;
            if (pin_s2_ff == pin_lvl_ff) begin
                flt_ff <= 4'h0;
            end else if (flt_ff == cfg_pkg::FLT_MAX - 4'h1) begin
                flt_ff     <= 4'h0;
                pin_lvl_ff <= pin_s2_ff;
            end else begin
                flt_ff <= flt_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bor_s1_ff <= 1'b0;
            bor_s2_ff <= 1'b0;
            bor_d_ff  <= 1'b0;
        end else begin
            bor_s1_ff <= brownout_det;
            bor_s2_ff <= bor_s1_ff;
            bor_d_ff  <= bor_s2_ff;
        end
    end

    assign pin_fall = ext_reset_pin_en && pin_lvl_d_ff && !pin_lvl_ff;
    assign bor_ev   = brownout_en && bor_s2_ff && !bor_d_ff;
    assign wdt_ev   = watchdog_en && wdt_timeout;
    assign any_rst  = bor_ev || pin_fall || (wdt_ev && !sleeping);
    assign core_reset  = any_rst;
    assign wake_resume = wdt_ev && sleeping && !bor_ev && !pin_fall;

    // cause and status flags, priority bor > pin > wdt
    always_ff @(posedge clk) begin
        if (reset) begin
            cause_ff <= cfg_pkg::CAUSE_POR;
            por_ff   <= 1'b0;
            bor_ff   <= 1'b1;
            to_ff    <= 1'b1;
            pd_ff    <= 1'b1;
        end else if (bor_ev) begin
            cause_ff <= cfg_pkg::CAUSE_BOR;
            bor_ff   <= 1'b0;
            to_ff    <= 1'b1;
            pd_ff    <= 1'b1;
        end else if (pin_fall) begin
            if (sleeping) begin
                cause_ff <= cfg_pkg::CAUSE_PIN_SLEEP;
                to_ff    <= 1'b1;
                pd_ff    <= 1'b0;
            end else begin
                cause_ff <= cfg_pkg::CAUSE_PIN_RUN;
            end
        end else if (wdt_ev) begin
            to_ff <= 1'b0;
            if (sleeping) begin
                cause_ff <= cfg_pkg::CAUSE_WDT_SLEEP;
                pd_ff    <= 1'b0;
            end else begin
                cause_ff <= cfg_pkg::CAUSE_WDT_RUN;
            end
        end else if (flag_wr) begin
            por_ff <= flag_wdata[1];
            bor_ff <= flag_wdata[0];
        end
    end

    assign timeout_flag    = to_ff;
    assign power_down_flag = pd_ff;
    assign por_flag        = por_ff;
    assign brownout_reset  = bor_ff;
    assign last_cause      = cause_ff;

    // unaffected register: no reset term at all
    always_ff @(posedge clk) begin
        if (keep_wr) begin
            keep_ff <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || any_rst) begin
            rst_ff <= cfg_pkg::REG_RESET_VAL;
        end else if (reg_wr) begin
            rst_ff <= reg_wdata;
        end
    end

    assign keep_reg  = keep_ff;
    assign reset_reg = rst_ff;

    a_wake_no_reset: assert property (@(posedge clk)
        disable iff (reset) wake_resume |-> !core_reset)
        else $error("wake reset regs");
    a_wdt_flag: assert property (@(posedge clk)
        disable iff (reset)
        (wdt_ev && !bor_ev && !pin_fall) |=> !timeout_flag)
        else $error("timeout flag not cleared");
    a_rst_clears: assert property (@(posedge clk)
        disable iff (reset)
        core_reset |=> reset_reg == cfg_pkg::REG_RESET_VAL)
        else $error("register not reset");
    a_keep_holds: assert property (@(posedge clk)
        disable iff (reset)
        (core_reset && !keep_wr) |=> $stable(keep_reg))
        else $error("unaffected register changed");
    a_bor_flag: assert property (@(posedge clk)
        disable iff (reset)
        bor_ev |=> !brownout_reset && timeout_flag && power_down_flag)
        else $error("brown-out flags wrong");
    // the pin must have been low at the start of the filter window
    a_glitch_filter: assert property (@(posedge clk)
        disable iff (reset) pin_fall |->
        ($past(pin_s2_ff, cfg_pkg::FILTER_CYC) == 1'b0))
        else $error("pin reset from glitch");
    a_pin_gate: assert property (@(posedge clk)
        disable iff (reset) !ext_reset_pin_en |-> !pin_fall)
        else $error("pin reset while internal");
    a_prog_lock: assert property (@(posedge clk)
        disable iff (reset)
        (!prog_mode && (prog_wr || prog_erase)) |=> $stable(nv_cfg_ff))
        else $error("config written outside programming");
    a_erase_cal: assert property (@(posedge clk)
        disable iff (reset)
        (prog_mode && prog_erase) |=> $stable(nv_cal_ff))
        else $error("erase touched calibration");
    a_bor_sleep: assert property (@(posedge clk)
        disable iff (reset) (sleeping &&
        cfg_ff[cfg_pkg::B_BOR_HI:cfg_pkg::B_BOR_LO] == cfg_pkg::BOR_SLEEP_OFF)
        |-> !brownout_en)
        else $error("brown-out active in sleep");
endmodule // config_word_and_reset_cause
`default_nettype wire

// ===== cfg_pkg.sv
// Purpose: constants for configuration word decode and reset-cause logic
// Assumes: 14-bit program memory words, erased bit reads as 1
// Notes:   programmed bit reads as 0
package cfg_pkg;
    localparam int          WORD_W          = 14;
    localparam int          ADDR_W          = 14;
    localparam logic [13:0] CONFIG_ADDR     = 14'h2007;
    localparam logic [13:0] CALIB_ADDR      = 14'h2008;
    localparam logic [13:0] SPECIAL_LO      = 14'h2000;
    localparam logic [13:0] SPECIAL_HI      = 14'h3FFF;
    localparam logic [13:0] ERASED_WORD     = 14'h3FFF;
    localparam logic [13:0] UNIMPL_MASK     = 14'h0086;
    localparam int          B_DEBUG         = 13;
    localparam int          B_CLKOUT        = 12;
    localparam int          B_WRT_HI        = 11;
    localparam int          B_WRT_LO        = 10;
    localparam int          B_BOR_HI        = 9;
    localparam int          B_BOR_LO        = 8;
    localparam int          B_CP            = 6;
    localparam int          B_RSTPIN        = 5;
    localparam int          B_PUT           = 4;
    localparam int          B_WDT           = 3;
    localparam int          B_OSC           = 0;
    localparam logic [1:0]  BOR_SLEEP_OFF   = 2'h2;
    localparam logic [1:0]  BOR_ON          = 2'h3;
    localparam int          FILTER_NS       = 100;
    localparam int          CLK_NS          = 10;
    localparam int          FILTER_CYC      = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int          FLT_W           = 4;
    localparam logic [3:0]  FLT_MAX         = 4'(FILTER_CYC);
    localparam logic [7:0]  KEEP_RESET      = 8'h00;
    localparam logic [7:0]  REG_RESET_VAL   = 8'h00;
    localparam logic [7:0]  CAL_RESET       = 8'h00;
    typedef enum logic [2:0] {
        CAUSE_NONE, CAUSE_POR, CAUSE_WDT_RUN, CAUSE_WDT_SLEEP,
        CAUSE_PIN_RUN, CAUSE_PIN_SLEEP, CAUSE_BOR
    } cause_e;
endpackage

// ===== prog_model.sv
// Purpose: device programmer model that writes configuration memory
// Assumes: requests change 1 ns after the rising clock edge
// Notes:   released data bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module prog_model (
    input  wire logic        clk,        // core clock
    output logic             prog_mode,  // programming mode
    output logic             prog_wr,    // write strobe
    output logic             prog_erase, // bulk erase strobe
    output logic      [13:0] prog_addr,  // word address
    output logic      [13:0] prog_wdata, // write data
    input  wire logic [13:0] prog_rdata  // readback
);
    initial begin
        prog_mode  = 1'b0;
        prog_wr    = 1'b0;
        prog_erase = 1'b0;
        prog_addr  = 14'h0000;
        prog_wdata = 14'h0000;
    end
    task automatic enter(input logic m);
        @(posedge clk);
        #1;
        prog_mode = m;
    endtask
    task automatic wr(input logic [13:0] a, input logic [13:0] d);
        @(posedge clk);
        #1;
        prog_addr  = a;
        prog_wdata = d;
        prog_wr    = 1'b1;
        @(posedge clk);
        #1;
        prog_wr    = 1'b0;
        prog_wdata = ~d;
    endtask
    task automatic erase();
        @(posedge clk);
        #1;
        prog_erase = 1'b1;
        @(posedge clk);
        #1;
        prog_erase = 1'b0;
    endtask
    task automatic rd(input logic [13:0] a, output logic [13:0] d);
        @(posedge clk);
        #1;
        prog_addr = a;
        repeat (2) @(posedge clk);
        #1;
        d = prog_rdata;
    endtask
endmodule // prog_model
`default_nettype wire

// ===== config_word_and_reset_cause_tb_top.sv
// Purpose: self-checking bench for configuration decode and reset causes
// Assumes: filter of 10 cycles, word applied on the next core reset
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module config_word_and_reset_cause_tb_top;
    logic        clk, reset, prog_mode, prog_wr, prog_erase, reset_pin_n;
    logic        brownout_det, wdt_timeout, sleeping, flag_wr, keep_wr;
    logic        reg_wr, debugger_en, clock_output_enable, brownout_en;
    logic        code_protect_en, ext_reset_pin_en, power_up_timer_en;
    logic        watchdog_en, ext_clock_sel, core_reset, wake_resume;
    logic        timeout_flag, power_down_flag, por_flag, brownout_reset;
    logic [13:0] prog_addr, prog_wdata, prog_rdata, device_configuration_word;
    logic [13:0] rv;
    logic [1:0]  flag_wdata, self_write_protect_field;
    logic [7:0]  reg_wdata, osc_trim, keep_reg, reset_reg;
    logic [2:0]  last_cause;
    int          failures, n_tests, n_rst, n_wake;
    config_word_and_reset_cause i_config_word_and_reset_cause (
        .clk, .reset, .prog_mode, .prog_wr, .prog_erase, .prog_addr,
        .prog_wdata, .prog_rdata, .reset_pin_n, .brownout_det, .wdt_timeout,
        .sleeping, .flag_wr, .flag_wdata, .reg_wdata, .keep_wr, .reg_wr,
        .device_configuration_word, .osc_trim, .debugger_en,
        .clock_output_enable, .self_write_protect_field, .brownout_en,
        .code_protect_en, .ext_reset_pin_en, .power_up_timer_en,
        .watchdog_en, .ext_clock_sel, .core_reset, .wake_resume,
        .timeout_flag, .power_down_flag, .por_flag, .brownout_reset,
        .last_cause, .keep_reg, .reset_reg);
    prog_model i_prog_model (.clk, .prog_mode, .prog_wr, .prog_erase,
        .prog_addr, .prog_wdata, .prog_rdata);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (core_reset === 1'b1) n_rst++;
        if (wake_resume === 1'b1) n_wake++;
    end
    task automatic complete_run();
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [13:0] g, input logic [13:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one reset situation with register writes just before it
    task automatic ev(input int k, input logic [2:0] c, input logic rs,
                      input logic t, input logic p, input logic b);
        int r0, w0;
        logic [7:0] v;
        v = 8'(8'h30 + k);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        keep_wr = 1'b1;
        reg_wdata = v;
        sleeping = (k == 2 || k == 3);
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        keep_wr = 1'b0;
        r0 = n_rst;
        w0 = n_wake;
        if (k == 0 || k == 2) wdt_timeout = 1'b1;
        if (k == 1 || k == 3) reset_pin_n = 1'b0;
        if (k == 4) brownout_det = 1'b1;
        @(posedge clk);
        #1;
        wdt_timeout = 1'b0;
        repeat (19) @(posedge clk);
        #1;
        reset_pin_n = 1'b1;
        brownout_det = 1'b0;
        repeat (30) @(posedge clk);
        #1;
        chk(14'(last_cause), 14'(c));
        chk(14'(timeout_flag), 14'(t));
        chk(14'(power_down_flag), 14'(p));
        chk(14'(brownout_reset), 14'(b));
        chk(14'(por_flag), 14'h0001);
        chk(14'(keep_reg), 14'(v));
        chk(14'(reset_reg), rs ? 14'h0000 : 14'(v));
        chk(14'(n_rst != r0), 14'(rs));
        chk(14'(n_wake != w0), 14'(!rs));
        sleeping = 1'b0;
    endtask
    task automatic glitch_test();
        int r0;
        r0 = n_rst;
        reset_pin_n = 1'b0;
        repeat (cfg_pkg::FILTER_CYC - 1) @(posedge clk);
        #1;
        reset_pin_n = 1'b1;
        repeat (30) @(posedge clk);
        #1;
        chk(14'(n_rst - r0), 14'h0000);
    endtask
    // software writes of the power-on and brown-out flags, ends at 11
    task automatic flag_test();
        logic [1:0] e;
        for (int i = 1; i < 4; i++) begin
            e = 2'(i);
            @(posedge clk);
            #1;
            flag_wr = 1'b1;
            flag_wdata = e;
            @(posedge clk);
            #1;
            flag_wr = 1'b0;
            chk(14'({por_flag, brownout_reset}), 14'(e));
        end
    endtask
    initial begin
        #50000;
        failures++;
        complete_run();
    end
    initial begin
        wdt_timeout = 1'b0;
        sleeping = 1'b0;
        flag_wr = 1'b0;
        keep_wr = 1'b0;
        reg_wr = 1'b0;
        brownout_det = 1'b0;
        flag_wdata = 2'b00;
        reg_wdata = 8'h00;
        reset_pin_n = 1'b1;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        @(posedge clk);
        #1;
        chk(14'(last_cause), 14'(cfg_pkg::CAUSE_POR));
        chk({10'h000, por_flag, brownout_reset, timeout_flag,
             power_down_flag}, 14'h0007);
        chk(device_configuration_word, 14'h3FFF);
        chk(14'(reset_reg), 14'h0000);
        glitch_test();
        i_prog_model.enter(1'b1);
        i_prog_model.wr(14'h2007, 14'h3A28);
        i_prog_model.wr(14'h2008, 14'h0055);
        i_prog_model.rd(14'h2007, rv);
        chk(rv, 14'h3AAE);
        i_prog_model.enter(1'b0);
        i_prog_model.wr(14'h2007, 14'h0000);
        i_prog_model.enter(1'b1);
        i_prog_model.rd(14'h2007, rv);
        chk(rv, 14'h3AAE);
        i_prog_model.enter(1'b0);
        flag_test();
        ev(0, cfg_pkg::CAUSE_WDT_RUN, 1'b1, 1'b0, 1'b1, 1'b1);
        chk(device_configuration_word, 14'h3AAE);
        chk(14'(osc_trim), 14'h0055);
        chk({9'h000, watchdog_en, ext_clock_sel, power_up_timer_en,
             self_write_protect_field}, 14'h0016);
        chk({10'h000, clock_output_enable, ext_reset_pin_en, code_protect_en,
             debugger_en}, 14'h0006);
        chk(14'(brownout_en), 14'h0001);
        sleeping = 1'b1;
        @(posedge clk);
        #1;
        chk(14'(brownout_en), 14'h0000);
        sleeping = 1'b0;
        ev(1, cfg_pkg::CAUSE_PIN_RUN, 1'b1, 1'b0, 1'b1, 1'b1);
        ev(2, cfg_pkg::CAUSE_WDT_SLEEP, 1'b0, 1'b0, 1'b0, 1'b1);
        ev(3, cfg_pkg::CAUSE_PIN_SLEEP, 1'b1, 1'b1, 1'b0, 1'b1);
        ev(4, cfg_pkg::CAUSE_BOR, 1'b1, 1'b1, 1'b1, 1'b0);
        i_prog_model.enter(1'b1);
        i_prog_model.erase();
        i_prog_model.rd(14'h2007, rv);
        chk(rv, 14'h3FFF);
        i_prog_model.enter(1'b0);
        ev(0, cfg_pkg::CAUSE_WDT_RUN, 1'b1, 1'b0, 1'b1, 1'b0);
        chk(14'(osc_trim), 14'h0055);
        chk(device_configuration_word, 14'h3FFF);
        chk({7'h00, debugger_en, clock_output_enable, code_protect_en,
             power_up_timer_en, watchdog_en, ext_clock_sel,
             ext_reset_pin_en}, 14'h0007);
        complete_run();
    end
endmodule // config_word_and_reset_cause_tb_top
`default_nettype wire
